// >>> inc/pmi_pkg.sv
// shared constants and helpers for both ends of the mac data link
package pmi_pkg;

    typedef enum logic [1:0] {
        PMI_MII,
        PMI_RMII,
        PMI_SERIAL
    } pmi_mode_t;

    // core clock
    localparam int MCLK_HZ = 100_000_000;
    localparam int CLK_NS = 1_000_000_000 / MCLK_HZ;

    // link clock rates
    localparam int F_25M_HZ = 25_000_000;
    localparam int F_2M5_HZ = 2_500_000;
    localparam int F_10M_HZ = 10_000_000;
    localparam int F_50M_HZ = 50_000_000;
    localparam int F_MDC_MAX_HZ = 25_000_000;

    // half periods in core cycles
    localparam logic [7:0] HALF_25M = 8'(MCLK_HZ / (2 * F_25M_HZ));
    localparam logic [7:0] HALF_2M5 = 8'(MCLK_HZ / (2 * F_2M5_HZ));
    localparam logic [7:0] HALF_10M = 8'(MCLK_HZ / (2 * F_10M_HZ));
    localparam logic [7:0] HALF_50M = 8'(MCLK_HZ / (2 * F_50M_HZ));
    // shortest legal management clock phase, rounded up
    localparam logic [7:0] MDC_HALF_MIN = 8'((MCLK_HZ + 2 * F_MDC_MAX_HZ - 1) / (2 * F_MDC_MAX_HZ));

    // heartbeat pulse length
    localparam int HB_NS = 1000;
    localparam logic [7:0] HB_CYC = 8'(HB_NS / CLK_NS);

    // phy samples transmit pins this many cycles after its own rising edge
    localparam int TX_SAMPLE_DLY = 5;
    localparam int RX_FIFO_DEPTH = 16;
    // receive fifo word: {last, err, byte}
    localparam int RX_WORD_W = 10;
    localparam int RXW_ERR = 8;
    localparam int RXW_LAST = 9;

    function automatic logic [3:0] sym_mask(input pmi_mode_t m);
        unique case (m)
            PMI_MII: return 4'hF;
            PMI_RMII: return 4'h3;
            default: return 4'h1;
        endcase
    endfunction

    function automatic logic [3:0] syms_per_byte(input pmi_mode_t m);
        unique case (m)
            PMI_MII: return 4'h2;
            PMI_RMII: return 4'h4;
            default: return 4'h8;
        endcase
    endfunction

    // lsb first: drop the symbol just sent
    function automatic logic [7:0] shift_out(input pmi_mode_t m, input logic [7:0] sh);
        unique case (m)
            PMI_MII: return {4'h0, sh[7:4]};
            PMI_RMII: return {2'h0, sh[7:2]};
            default: return {1'h0, sh[7:1]};
        endcase
    endfunction

    // lsb first: new symbol enters at the top
    function automatic logic [7:0] shift_in(input pmi_mode_t m, input logic [7:0] sh, input logic [3:0] s);
        unique case (m)
            PMI_MII: return {s[3:0], sh[7:4]};
            PMI_RMII: return {s[1:0], sh[7:2]};
            default: return {s[0], sh[7:1]};
        endcase
    endfunction

endpackage

// >>> inc/pmi_link_if.sv
// mac data link pins between the phy end and the mac end
interface pmi_link_if;
    logic tx_clk;
    logic rx_clk;
    logic ref_clk;
    logic tx_en;
    logic [3:0] txd;
    logic [3:0] rxd;
    logic rx_dv;
    logic crs;
    logic rx_er;
    logic col;
    logic mdc;

    modport phy (
        output tx_clk, rx_clk, ref_clk, rxd, rx_dv, crs, rx_er, col,
        input tx_en, txd, mdc
    );

    modport mac (
        input tx_clk, rx_clk, ref_clk, rxd, rx_dv, crs, rx_er, col,
        output tx_en, txd, mdc
    );
endinterface

// >>> rtl/pmi_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides
module pmi_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // fill side
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // drain side
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("pmi_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic ready_q;

    wire push = in_valid_i & ready_q;
    wire pop = out_valid_o & out_ready_i;

    assign cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o = mem_q[rd_q];
    assign in_ready_o = ready_q;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b0;
        end else begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            cnt_q <= cnt_d;
            // registered so the filling side sees a flop
            ready_q <= cnt_d != FULL;
        end
    end
endmodule // pmi_fifo

// >>> rtl/pmi_phy_end.sv
// phy end of the mac data link: clocks, receive serialiser, transmit capture, collision
//
// Overview of operation
// - management clock at most 25 MHz, asynchronous
// - MII transmit clock 25 or 2.5 MHz
// - RMII uses 50 MHz reference, no clocks
// - serial mode 10 MHz clock, mac launches
// - transmit enable qualifies 4, 2, 1 bits
// - MII transmit nibble sampled on transmit clock
// - RMII transmit dibit sampled on reference clock
// - receive clock 25, 2.5 or 10 MHz
// - MII receive nibble valid under data valid
// - RMII data valid driven identical to carrier
// - MII 100 Mb/s invalid symbol raises error
// - RMII 100 Mb/s media error raises error
// - receive error also corrupts delivered data
// - serial mode leaves error and valid idle
// - RMII receive dibit on reference clock
// - serial receive uses bit zero only
// - carrier sense high while medium busy
// - RMII carrier merged with data valid
// - half duplex overlap raises collision
// - 10 Mb/s heartbeat pulse about 1 us
// - full duplex keeps collision low
// - RMII mac derives collision itself
module pmi_phy_end #(
    parameter int unsigned FIFO_DEPTH = pmi_pkg::RX_FIFO_DEPTH,
    parameter int unsigned TX_SAMPLE_DLY = pmi_pkg::TX_SAMPLE_DLY
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // configuration
    input wire pmi_pkg::pmi_mode_t mode_i,
    input wire logic speed100_i,
    input wire logic full_duplex_i,
    input wire logic heartbeat_en_i,
    // link to the mac
    pmi_link_if.phy link,
    // receive stream from the line side
    input wire logic [7:0] rx_data_i,
    input wire logic rx_err_i,
    input wire logic rx_last_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    // transmit symbols toward the line side
    output logic [3:0] tx_sym_o,
    output logic tx_sym_valid_o,
    output logic tx_active_o,
    // status
    output logic mdc_fast_o
);
    if (TX_SAMPLE_DLY < 1 || TX_SAMPLE_DLY > 16) begin : g_chk
        $error("pmi_phy_end: TX_SAMPLE_DLY out of range");
    end

    // link clock generator
    logic [7:0] cnt_q;
    logic lclk_q;
    logic tx_clk_q;
    logic rx_clk_q;
    logic ref_clk_q;
    wire [7:0] half_sel;
    wire wrap;
    wire lclk_d;
    wire rise;
    wire is_rmii = mode_i == pmi_pkg::PMI_RMII;
    wire is_ser = mode_i == pmi_pkg::PMI_SERIAL;

    assign half_sel = is_rmii ? pmi_pkg::HALF_50M :
                      is_ser ? pmi_pkg::HALF_10M :
                      speed100_i ? pmi_pkg::HALF_25M : pmi_pkg::HALF_2M5;
    // >= so a mode change to a shorter period never stalls the divider
    assign wrap = cnt_q >= half_sel - 8'h01;
    assign lclk_d = wrap ? ~lclk_q : lclk_q;
    assign rise = wrap & ~lclk_q;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_q <= 8'h00;
            lclk_q <= 1'b0;
            tx_clk_q <= 1'b0;
            rx_clk_q <= 1'b0;
            ref_clk_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
            lclk_q <= lclk_d;
            tx_clk_q <= ~is_rmii & lclk_d;
            rx_clk_q <= ~is_rmii & lclk_d;
            ref_clk_q <= is_rmii & lclk_d;
        end
    end

    // pin synchronisers: {mdc, tx_en, txd}
    logic [5:0] pin_s1_q;
    logic [5:0] pin_s2_q;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pin_s1_q <= 6'h00;
            pin_s2_q <= 6'h00;
        end else begin
            pin_s1_q <= {link.mdc, link.tx_en, link.txd};
            pin_s2_q <= pin_s1_q;
        end
    end
    wire [3:0] txd_s = pin_s2_q[3:0];
    wire tx_en_s = pin_s2_q[4];
    wire mdc_s = pin_s2_q[5];

    // transmit capture; delay covers the mac's sampling and launch latency
    logic [TX_SAMPLE_DLY-1:0] rise_pipe_q;
    logic [3:0] tx_sym_q;
    logic tx_sym_valid_q;
    logic tx_active_q;
    wire sample = rise_pipe_q[TX_SAMPLE_DLY-1];
    wire tx_end = sample & tx_active_q & ~tx_en_s;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rise_pipe_q <= '0;
            tx_sym_q <= 4'h0;
            tx_sym_valid_q <= 1'b0;
            tx_active_q <= 1'b0;
        end else begin
            // oldest stage drops out of the top
            rise_pipe_q <= TX_SAMPLE_DLY'({rise_pipe_q, rise});
            tx_sym_valid_q <= sample & tx_en_s;
            if (sample) begin
                // width follows mode: nibble, dibit or single bit
                tx_sym_q <= txd_s & pmi_pkg::sym_mask(mode_i);
                tx_active_q <= tx_en_s;
            end
        end
    end

    // receive path: line bytes buffered, then serialised lsb first
    logic [pmi_pkg::RX_WORD_W-1:0] fifo_data;
    logic fifo_valid;
    logic [7:0] sh_q;
    logic [3:0] left_q;
    logic err_q;
    logic last_q;
    logic gap_q;
    logic [3:0] rxd_q;
    logic rx_dv_q;
    logic crs_q;
    logic rx_er_q;

    wire load = left_q == 4'h0 && ~gap_q && fifo_valid;
    wire pop = rise & load;
    wire emit = left_q != 4'h0 || load;
    wire [7:0] cur = load ? fifo_data[7:0] : sh_q;
    wire cur_err = load ? fifo_data[pmi_pkg::RXW_ERR] : err_q;
    wire cur_last = load ? fifo_data[pmi_pkg::RXW_LAST] : last_q;
    wire [3:0] left_d = (load ? pmi_pkg::syms_per_byte(mode_i) : left_q) - 4'h1;
    // flipping every bit makes the mac's frame check fail
    wire [3:0] sym_out = (cur[3:0] ^ {4{cur_err}}) & pmi_pkg::sym_mask(mode_i);

    pmi_fifo #(
        .W(pmi_pkg::RX_WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .in_data_i({rx_last_i, rx_err_i, rx_data_i}),
        .in_valid_i(rx_valid_i),
        .in_ready_o(rx_ready_o),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop)
    );

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sh_q <= 8'h00;
            left_q <= 4'h0;
            err_q <= 1'b0;
            last_q <= 1'b0;
            gap_q <= 1'b0;
            rxd_q <= 4'h0;
            rx_dv_q <= 1'b0;
            crs_q <= 1'b0;
            rx_er_q <= 1'b0;
        end else if (rise) begin
            // outputs change with the receive clock's rising edge
            if (emit) begin
                rxd_q <= sym_out;
                sh_q <= pmi_pkg::shift_out(mode_i, cur);
                left_q <= left_d;
                err_q <= cur_err;
                last_q <= cur_last;
                // one idle symbol after a frame so the mac sees its end
                gap_q <= cur_last && left_d == 4'h0;
                rx_er_q <= cur_err & speed100_i & ~is_ser;
                rx_dv_q <= ~is_ser;
                crs_q <= 1'b1;
            end else begin
                rxd_q <= 4'h0;
                gap_q <= 1'b0;
                rx_er_q <= 1'b0;
                rx_dv_q <= 1'b0;
                crs_q <= 1'b0;
            end
        end
    end

    // collision and heartbeat
    logic [7:0] hb_q;
    logic col_q;
    wire ten_mb = is_ser | (~is_rmii & ~speed100_i);
    wire hb_start = tx_end & ten_mb & ~full_duplex_i & heartbeat_en_i & ~is_rmii;
    wire overlap = tx_active_q & crs_q;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hb_q <= 8'h00;
            col_q <= 1'b0;
        end else begin
            if (hb_start) begin
                hb_q <= pmi_pkg::HB_CYC;
            end else if (hb_q != 8'h00) begin
                hb_q <= hb_q - 8'h01;
            end
            // no collision pin in reduced mode; the mac works it out
            col_q <= ~is_rmii & ~full_duplex_i & (overlap | hb_q != 8'h00);
        end
    end

    // management clock phase check; slow or stopped clocks are fine
    logic mdc_prev_q;
    logic [7:0] phase_q;
    logic mdc_fast_q;
    wire mdc_tog = mdc_s ^ mdc_prev_q;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mdc_prev_q <= 1'b0;
            phase_q <= 8'hFF;
            mdc_fast_q <= 1'b0;
        end else begin
            mdc_prev_q <= mdc_s;
            if (mdc_tog) begin
                phase_q <= 8'h00;
                // saturated count means a long phase; adding one would wrap to zero
                if (phase_q != 8'hFF && phase_q + 8'h01 < pmi_pkg::MDC_HALF_MIN) begin
                    mdc_fast_q <= 1'b1;
                end
            end else if (phase_q != 8'hFF) begin
                phase_q <= phase_q + 8'h01;
            end
        end
    end

    // pin and port drive
    assign link.tx_clk = tx_clk_q;
    assign link.rx_clk = rx_clk_q;
    assign link.ref_clk = ref_clk_q;
    assign link.rxd = rxd_q;
    assign link.rx_dv = rx_dv_q;
    assign link.crs = crs_q;
    assign link.rx_er = rx_er_q;
    assign link.col = col_q;
    assign tx_sym_o = tx_sym_q;
    assign tx_sym_valid_o = tx_sym_valid_q;
    assign tx_active_o = tx_active_q;
    assign mdc_fast_o = mdc_fast_q;
endmodule // pmi_phy_end

// >>> rtl/pmi_mac_end.sv
// mac end of the mac data link: transmit serialiser, receive assembly, management clock
module pmi_mac_end #(
    parameter logic [7:0] MDC_HALF = pmi_pkg::MDC_HALF_MIN
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // configuration
    input wire pmi_pkg::pmi_mode_t mode_i,
    // link to the phy
    pmi_link_if.mac link,
    // transmit bytes
    input wire logic [7:0] tx_data_i,
    input wire logic tx_last_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    // receive bytes
    output logic [7:0] rx_data_o,
    output logic rx_err_o,
    output logic rx_valid_o,
    output logic rx_end_o,
    // link state
    output logic col_o
);
    if (MDC_HALF < pmi_pkg::MDC_HALF_MIN) begin : g_chk
        $error("pmi_mac_end: management clock would exceed its limit");
    end

    wire is_rmii = mode_i == pmi_pkg::PMI_RMII;
    wire is_ser = mode_i == pmi_pkg::PMI_SERIAL;

    // synchronisers: {col, rx_er, crs, rx_dv, rxd, ref, rx_clk, tx_clk}
    logic [10:0] s1_q;
    logic [10:0] s2_q;
    logic txc_prev_q;
    logic rxc_prev_q;
    // reduced mode runs both directions from the reference
    wire txc_s = is_rmii ? s2_q[2] : s2_q[0];
    wire rxc_s = is_rmii ? s2_q[2] : s2_q[1];
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            s1_q <= 11'h000;
            s2_q <= 11'h000;
            txc_prev_q <= 1'b0;
            rxc_prev_q <= 1'b0;
        end else begin
            s1_q <= {link.col, link.rx_er, link.crs, link.rx_dv, link.rxd, link.ref_clk, link.rx_clk, link.tx_clk};
            s2_q <= s1_q;
            txc_prev_q <= txc_s;
            rxc_prev_q <= rxc_s;
        end
    end
    wire [3:0] rxd_s = s2_q[6:3];
    wire dv_s = s2_q[7];
    wire crs_s = s2_q[8];
    wire er_s = s2_q[9];
    wire col_s = s2_q[10];
    wire tx_rise = txc_s & ~txc_prev_q;
    wire rx_rise = rxc_s & ~rxc_prev_q;

    // transmit: holding register, then serialise lsb first on the link clock
    logic [7:0] hold_q;
    logic hold_last_q;
    logic hold_empty_q;
    logic [7:0] sh_q;
    logic [3:0] left_q;
    logic last_q;
    logic gap_q;
    logic tx_en_q;
    logic [3:0] txd_q;
    wire accept = tx_valid_i & hold_empty_q;
    wire load = tx_rise && left_q == 4'h0 && ~gap_q && ~hold_empty_q;
    wire [7:0] cur = load ? hold_q : sh_q;
    wire cur_last = load ? hold_last_q : last_q;
    wire [3:0] left_d = (load ? pmi_pkg::syms_per_byte(mode_i) : left_q) - 4'h1;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hold_q <= 8'h00;
            hold_last_q <= 1'b0;
            hold_empty_q <= 1'b1;
        end else if (accept) begin
            hold_q <= tx_data_i;
            hold_last_q <= tx_last_i;
            hold_empty_q <= 1'b0;
        end else if (load) begin
            hold_empty_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sh_q <= 8'h00;
            left_q <= 4'h0;
            last_q <= 1'b0;
            gap_q <= 1'b0;
            tx_en_q <= 1'b0;
            txd_q <= 4'h0;
        end else if (tx_rise) begin
            // launched from the phy's clock edge as it arrives
            if (load || left_q != 4'h0) begin
                txd_q <= cur[3:0] & pmi_pkg::sym_mask(mode_i);
                tx_en_q <= 1'b1;
                sh_q <= pmi_pkg::shift_out(mode_i, cur);
                left_q <= left_d;
                last_q <= cur_last;
                gap_q <= cur_last && left_d == 4'h0;
            end else begin
                txd_q <= 4'h0;
                tx_en_q <= 1'b0;
                gap_q <= 1'b0;
            end
        end
    end

    // receive: qualifier depends on mode
    logic [7:0] rsh_q;
    logic [3:0] rcnt_q;
    logic racc_err_q;
    logic in_frame_q;
    logic [7:0] rx_data_q;
    logic rx_err_q;
    logic rx_valid_q;
    logic rx_end_q;
    wire qual = (is_rmii | is_ser) ? crs_s : dv_s;
    wire [7:0] rsh_d = pmi_pkg::shift_in(mode_i, rsh_q, rxd_s);
    wire racc_d = racc_err_q | (er_s & ~is_ser);
    wire byte_done = rcnt_q == pmi_pkg::syms_per_byte(mode_i) - 4'h1;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rsh_q <= 8'h00;
            rcnt_q <= 4'h0;
            racc_err_q <= 1'b0;
            in_frame_q <= 1'b0;
            rx_data_q <= 8'h00;
            rx_err_q <= 1'b0;
            rx_valid_q <= 1'b0;
            rx_end_q <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            rx_end_q <= 1'b0;
            if (rx_rise) begin
                in_frame_q <= qual;
                if (qual) begin
                    rsh_q <= rsh_d;
                    rcnt_q <= byte_done ? 4'h0 : rcnt_q + 4'h1;
                    racc_err_q <= byte_done ? 1'b0 : racc_d;
                    if (byte_done) begin
                        rx_data_q <= rsh_d;
                        rx_err_q <= racc_d;
                        rx_valid_q <= 1'b1;
                    end
                end else begin
                    // a partial byte at frame end is dropped
                    rcnt_q <= 4'h0;
                    racc_err_q <= 1'b0;
                    rx_end_q <= in_frame_q;
                end
            end
        end
    end

    // collision: pin, or own transmit against merged carrier in reduced mode
    logic col_q;
    logic [7:0] mdc_cnt_q;
    logic mdc_q;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            col_q <= 1'b0;
            mdc_cnt_q <= 8'h00;
            mdc_q <= 1'b0;
        end else begin
            col_q <= is_rmii ? (crs_s & tx_en_q) : col_s;
            // free-running divider keeps each phase at or above the limit
            if (mdc_cnt_q >= MDC_HALF - 8'h01) begin
                mdc_cnt_q <= 8'h00;
                mdc_q <= ~mdc_q;
            end else begin
                mdc_cnt_q <= mdc_cnt_q + 8'h01;
            end
        end
    end

    assign link.tx_en = tx_en_q;
    assign link.txd = txd_q;
    assign link.mdc = mdc_q;
    assign tx_ready_o = hold_empty_q;
    assign rx_data_o = rx_data_q;
    assign rx_err_o = rx_err_q;
    assign rx_valid_o = rx_valid_q;
    assign rx_end_o = rx_end_q;
    assign col_o = col_q;
endmodule // pmi_mac_end

// >>> dv/pmi_link_monitor.sv
// concurrent checks on the mac data link pins
module pmi_link_monitor (
    // clock, reset and configuration
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire pmi_pkg::pmi_mode_t mode_i,
    input wire logic speed100_i,
    input wire logic full_duplex_i,
    // link pins
    input wire logic tx_clk,
    input wire logic rx_clk,
    input wire logic ref_clk,
    input wire logic [3:0] rxd,
    input wire logic rx_dv,
    input wire logic crs,
    input wire logic rx_er,
    input wire logic col
);
    wire logic is_mii = (mode_i == pmi_pkg::PMI_MII);
    wire logic is_rmii = (mode_i == pmi_pkg::PMI_RMII);
    wire logic is_ser = (mode_i == pmi_pkg::PMI_SERIAL);

    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_rmii_clk_quiet:
        assert property (is_rmii |-> !tx_clk && !rx_clk) else $error("link clock runs in rmii");
    a_ref_rmii_only:
        assert property (!is_rmii |-> !ref_clk) else $error("reference toggles outside rmii");
    a_mii100_tx_period:
        assert property (is_mii && speed100_i && $rose(tx_clk) |=> tx_clk ##1 !tx_clk [*2] ##1 tx_clk)
        else $error("mii 100 transmit clock period wrong");
    a_mii10_rx_period:
        assert property (is_mii && !speed100_i && $rose(rx_clk) |-> ##20 $fell(rx_clk) ##20 $rose(rx_clk))
        else $error("mii 10 receive clock period wrong");
    a_serial_tx_period:
        assert property (is_ser && $rose(tx_clk) |-> ##5 $fell(tx_clk) ##5 $rose(tx_clk))
        else $error("serial transmit clock period wrong");
    a_serial_unused_pins:
        assert property (is_ser |-> !rx_dv && !rx_er && rxd[3:1] == 3'h0) else $error("serial unused pin driven");
    a_rmii_rxd_width:
        assert property (is_rmii |-> rxd[3:2] == 2'h0) else $error("rmii upper receive bits driven");
    a_dv_needs_crs:
        assert property (is_mii && rx_dv |-> crs) else $error("data valid without carrier");
    a_er_in_frame:
        assert property (rx_er |-> crs && !is_ser) else $error("receive error outside frame");
    a_rmii_no_col:
        assert property (is_rmii |-> !col) else $error("collision driven in rmii");
    a_fd_col_low:
        assert property (full_duplex_i |-> !col) else $error("collision in full duplex");
endmodule // pmi_link_monitor

// >>> dv/phy_mac_side_data_interface_test.sv
// self-checking bench joining both link ends across the pin interface
module phy_mac_side_data_interface_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    pmi_pkg::pmi_mode_t mode_i = pmi_pkg::PMI_MII;
    logic speed100_i = 1'b1;
    logic full_duplex_i = 1'b0;
    logic heartbeat_en_i = 1'b0;
    logic [7:0] rx_data_i = 8'h00;
    logic rx_err_i = 1'b0;
    logic rx_last_i = 1'b0;
    logic rx_valid_i = 1'b0;
    logic [7:0] tx_data_i = 8'h00;
    logic tx_last_i = 1'b0;
    logic tx_valid_i = 1'b0;
    logic rx_ready_o, tx_sym_valid_o, tx_active_o, mdc_fast_o, tx_ready_o;
    logic rx_err_o, rx_valid_o, rx_end_o, col_o;
    logic [3:0] tx_sym_o;
    logic [7:0] rx_data_o;
    logic [7:0] acc = 8'h00;
    int n_mismatch = 0;
    int check_count = 0;
    int tx_got, rx_got, nb, wid, col_cnt, ends;

    pmi_link_if link ();
    pmi_phy_end u_pmi_phy_end (.mclk_i, .sys_rst_i, .mode_i, .speed100_i, .full_duplex_i, .heartbeat_en_i,
        .link, .rx_data_i, .rx_err_i, .rx_last_i, .rx_valid_i, .rx_ready_o, .tx_sym_o, .tx_sym_valid_o,
        .tx_active_o, .mdc_fast_o);
    pmi_mac_end u_pmi_mac_end (.mclk_i, .sys_rst_i, .mode_i, .link, .tx_data_i, .tx_last_i, .tx_valid_i,
        .tx_ready_o, .rx_data_o, .rx_err_o, .rx_valid_o, .rx_end_o, .col_o);
    pmi_link_monitor u_pmi_link_monitor (.mclk_i, .sys_rst_i, .mode_i, .speed100_i, .full_duplex_i,
        .tx_clk(link.tx_clk), .rx_clk(link.rx_clk), .ref_clk(link.ref_clk), .rxd(link.rxd),
        .rx_dv(link.rx_dv), .crs(link.crs), .rx_er(link.rx_er), .col(link.col));

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    function automatic logic [7:0] exp_byte(input int i);
        return 8'(8'hA5 + 8'h36 * i);
    endfunction

    function automatic bit ok(input bit c);
        check_count++;
        return c;
    endfunction

    task automatic bad(input string m);
        $display("BAD %0t %s", $time, m);
        n_mismatch++;
    endtask

    task automatic test_done;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic hang(input string m);
        bad(m);
        test_done;
    endtask

    // one byte per call; byte 2 of the receive frame carries an error
    task automatic push(input bit rx, input int i);
        int k;
        if (rx) begin
            rx_data_i <= exp_byte(i);
            rx_err_i <= (i == 2);
            rx_last_i <= (i == 3);
            rx_valid_i <= 1'b1;
        end else begin
            tx_data_i <= exp_byte(i);
            tx_last_i <= (i == 3);
            tx_valid_i <= 1'b1;
        end
        k = 0;
        do begin
            @(posedge mclk_i);
            k++;
        end while ((rx ? rx_ready_o : tx_ready_o) !== 1'b1 && k < 3000);
        if (k >= 3000) hang("stream stall");
    endtask

    // both directions at once so receive carrier overlaps own transmit
    task automatic run_cfg(input pmi_pkg::pmi_mode_t m, input logic s, input logic f, input logic h);
        int k;
        sys_rst_i <= 1'b1;
        mode_i <= m;
        speed100_i <= s;
        full_duplex_i <= f;
        heartbeat_en_i <= h;
        repeat (20) @(posedge mclk_i);
        {tx_got, rx_got, nb, col_cnt, ends} = '0;
        wid = (m == pmi_pkg::PMI_MII) ? 4 : (m == pmi_pkg::PMI_RMII) ? 2 : 1;
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        fork
            begin
                for (int i = 0; i < 4; i++)
                    push(1'b0, i);
                tx_valid_i <= 1'b0;
            end
            begin
                for (int i = 0; i < 4; i++)
                    push(1'b1, i);
                rx_valid_i <= 1'b0;
            end
        join
        k = 0;
        while ((tx_got < 4 || rx_got < 4) && k < 3000) begin
            @(posedge mclk_i);
            k++;
        end
        if (k >= 3000) hang("frame lost");
        // room for the frame gap and the heartbeat pulse
        repeat (300) @(posedge mclk_i);
        if (!ok(ends == 1)) bad("frame end count");
        if (!ok(f ? col_cnt == 0 : col_cnt > 0)) bad("collision");
        if (!ok(mdc_fast_o === 1'b0)) bad("management clock too fast");
        if (!ok(tx_active_o === 1'b0)) bad("transmit still active");
    endtask

    always @(posedge mclk_i) begin
        if (sys_rst_i === 1'b0 && tx_sym_valid_o === 1'b1) begin
            for (int b = 0; b < wid; b++) begin
                acc = {tx_sym_o[b], acc[7:1]};
                nb++;
            end
            if (nb == 8) begin
                if (!ok(acc === exp_byte(tx_got))) bad("tx byte");
                tx_got++;
                nb = 0;
            end
        end
        if (sys_rst_i === 1'b0 && rx_valid_o === 1'b1) begin
            if (!ok(rx_data_o === (exp_byte(rx_got) ^ (rx_got == 2 ? 8'hFF : 8'h00)))) bad("rx byte");
            if (!ok(rx_err_o === (rx_got == 2 && speed100_i && wid != 1))) bad("rx err");
            rx_got++;
        end
        if (rx_end_o === 1'b1) ends++;
        if (col_o === 1'b1) col_cnt++;
    end

    initial begin
        run_cfg(pmi_pkg::PMI_MII, 1'b1, 1'b0, 1'b0);
        run_cfg(pmi_pkg::PMI_MII, 1'b0, 1'b1, 1'b0);
        run_cfg(pmi_pkg::PMI_RMII, 1'b1, 1'b0, 1'b0);
        run_cfg(pmi_pkg::PMI_SERIAL, 1'b0, 1'b0, 1'b1);
        test_done;
    end
endmodule // phy_mac_side_data_interface_test
